// ### inc/gtc_pkg.sv
package gtc_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int PS_W = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] GATE_SRC_OFF = 12'h004;
  localparam logic [ADDR_W-1:0] COUNT_OFF = 12'h008;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h00C;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [0:0] GATE_SRC_RST = 1'h0;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;

  // counter_control_reg fields
  localparam int POL_BIT = 7;
  localparam int GATE_EN_BIT = 6;
  localparam int PS_LSB = 4;
  localparam int OSC_EN_BIT = 3;
  localparam int NOSYNC_BIT = 2;
  localparam int CS_BIT = 1;
  localparam int ON_BIT = 0;

  // comparator_control_reg field
  localparam int GSS_BIT = 0;

  // status fields
  localparam int ST_GATE_OPEN_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int ST_EXT_LVL_BIT = 2;

  // prescale codes
  localparam logic [PS_W-1:0] PS_DIV1 = 2'h0;
  localparam logic [PS_W-1:0] PS_DIV8 = 2'h3;

  // timing: mclk is the instruction clock, i.e. the oscillator over four
  localparam int MCLK_PERIOD_NS = 50;
  localparam int OSC_DIV = 4;
  localparam int OSC_PERIOD_NS = MCLK_PERIOD_NS / OSC_DIV;
  localparam int INT_TICK_CYCLES = (OSC_PERIOD_NS * OSC_DIV)
                                   / MCLK_PERIOD_NS;
  localparam int DIV8_SPACING = 8;

endpackage : gtc_pkg

// ### hw/gtc_prescaler.sv
`timescale 1ns/1ps
module gtc_prescaler #(
  parameter int SEL_W = 2
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // tick path
  input wire logic tick_in,
  input wire logic [SEL_W-1:0] sel_in,
  input wire logic clr_in,
  output logic tick_out
);

  localparam int DIV_W = (1 << SEL_W) - 1;

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] mask;

  // divide by two to the power sel: pass every tick whose low bits are ones
  always_comb begin
    mask = DIV_W'((1 << sel_in) - 1);
    tick_out = tick_in && ((cnt & mask) == mask);
  end

  // cleared on reconfiguration so a new ratio starts from a clean phase
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= '0;
    end else if (clr_in) begin
      cnt <= '0;
    end else if (tick_in) begin
      cnt <= cnt + DIV_W'(1);
    end
  end

endmodule : gtc_prescaler

// ### hw/gtc_top.sv
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: polarity bit picks gate level that counts
// RULE_02: polarity applies to pin and comparator gate
// RULE_03: gate enable matters only while counter on
// RULE_04: gate enable clear means always counting
// RULE_05: prescale codes divide by 1, 2, 4, 8
// RULE_06: oscillator enable runs low-power clock source
// RULE_07: external clock synchronised unless sync bit set
// RULE_08: internal source ignores the sync bit
// RULE_09: source bit picks pin edges or Fosc/4
// RULE_10: on bit starts counting, clear holds value
// RULE_11: software enables gating before using gate sources
// RULE_12: one increment per prescaled tick when allowed
module gtc_top #(
  parameter int CNT_W = gtc_pkg::CNT_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [gtc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [gtc_pkg::DATA_W-1:0] pwdata_in,
  output logic [gtc_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // count clock and gate pins
  input wire logic ext_count_clock_pin_in,
  input wire logic lp_osc_clock_in,
  input wire logic gate_pin_in,
  input wire logic second_comparator_output_in,
  // timer outputs
  output logic low_power_osc_enable_out,
  output logic [CNT_W-1:0] count_value_out,
  output logic rollover_out
);

  logic [7:0] counter_control_reg;
  logic gate_source_select;
  logic [CNT_W-1:0] count;

  logic counter_on;
  logic gate_polarity;
  logic gate_enable_bit;
  logic [gtc_pkg::PS_W-1:0] prescale_select;
  logic low_power_osc_enable;
  logic ext_clock_sync_control;
  logic clock_source_select;

  // apb handshake
  logic access;
  logic ctrl_wr;
  logic gss_wr;
  logic count_wr;

  // synchronisers: stage one read only by stage two
  logic [1:0] ext_s1;
  logic [1:0] ext_s2;
  logic ext_s3;
  logic ext_rise_d;
  logic pin_s1;
  logic pin_s2;
  logic cmp_s1;
  logic cmp_s2;

  logic ext_src;
  logic ext_rise;
  logic ext_tick;
  logic src_tick;
  logic gate_lvl;
  logic gate_open;
  logic run;
  logic count_up;

  function automatic logic addr_hit(
    input logic [gtc_pkg::ADDR_W-1:0] a
  );
    addr_hit = (a == gtc_pkg::CTRL_OFF) || (a == gtc_pkg::GATE_SRC_OFF) ||
               (a == gtc_pkg::COUNT_OFF) || (a == gtc_pkg::STATUS_OFF);
  endfunction : addr_hit

  assign counter_on = counter_control_reg[gtc_pkg::ON_BIT];
  assign gate_polarity = counter_control_reg[gtc_pkg::POL_BIT];
  assign gate_enable_bit = counter_control_reg[gtc_pkg::GATE_EN_BIT];
  assign prescale_select =
    counter_control_reg[gtc_pkg::PS_LSB +: gtc_pkg::PS_W];
  assign low_power_osc_enable = counter_control_reg[gtc_pkg::OSC_EN_BIT];
  assign ext_clock_sync_control = counter_control_reg[gtc_pkg::NOSYNC_BIT];
  assign clock_source_select = counter_control_reg[gtc_pkg::CS_BIT];

  // writes land on the edge where pready is seen high
  assign access = psel_in && penable_in && pready_out;
  assign ctrl_wr = access && pwrite_in && (paddr_in == gtc_pkg::CTRL_OFF);
  assign gss_wr = access && pwrite_in &&
                  (paddr_in == gtc_pkg::GATE_SRC_OFF);
  assign count_wr = access && pwrite_in && (paddr_in == gtc_pkg::COUNT_OFF);

  // one wait state: pready is a flop so read data can be registered too
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pslverr_out <= 1'b0;
    end else if (psel_in && penable_in && !pready_out) begin
      pslverr_out <= !addr_hit(paddr_in);
    end else if (!psel_in) begin
      pslverr_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= '0;
    end else if (psel_in && penable_in && !pready_out && !pwrite_in) begin
      unique case (paddr_in)
        gtc_pkg::CTRL_OFF: begin
          prdata_out <= {24'h000000, counter_control_reg};
        end
        gtc_pkg::GATE_SRC_OFF: begin
          prdata_out <= {31'h0, gate_source_select};
        end
        gtc_pkg::COUNT_OFF: begin
          prdata_out <= gtc_pkg::DATA_W'(count);
        end
        gtc_pkg::STATUS_OFF: begin
          prdata_out <= {29'h0, ext_src, run, gate_open};
        end
        default: begin
          prdata_out <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter_control_reg <= gtc_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      counter_control_reg <= pwdata_in[7:0];
    end
  end

  // gate source lives in the comparator block; mirrored here as one bit
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_source_select <= gtc_pkg::GATE_SRC_RST;
    end else if (gss_wr) begin
      gate_source_select <= pwdata_in[gtc_pkg::GSS_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_power_osc_enable_out <= 1'b0;
    end else begin
      low_power_osc_enable_out <= ctrl_wr ?                    // RULE_06
        pwdata_in[gtc_pkg::OSC_EN_BIT] : low_power_osc_enable;
    end
  end

  // with the oscillator on, its output replaces the count pin
  assign ext_src = low_power_osc_enable ? ext_s2[1]         // RULE_06
                                        : ext_s2[0];

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_s1 <= '0;
      ext_s2 <= '0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= {lp_osc_clock_in, ext_count_clock_pin_in};
      ext_s2 <= ext_s1;
      ext_s3 <= ext_src;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      pin_s1 <= gate_pin_in;
      pin_s2 <= pin_s1;
      cmp_s1 <= second_comparator_output_in;
      cmp_s2 <= cmp_s1;
    end
  end

  // rising edges only; the extra stage aligns them to the instruction cycle
  assign ext_rise = ext_src && !ext_s3;                      // RULE_09

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_rise_d <= 1'b0;
    end else begin
      ext_rise_d <= ext_rise;
    end
  end

  // the pins always pass the metastability guard, so the unsynchronised
  // mode only saves the alignment stage
  assign ext_tick = ext_clock_sync_control ? ext_rise     // RULE_07
                                           : ext_rise_d;
  // mclk is the instruction clock, so internal ticks every cycle
  assign src_tick = clock_source_select ? ext_tick : 1'b1;  // RULE_08 RULE_09

  assign gate_lvl = gate_source_select ? cmp_s2 : pin_s2;
  assign gate_open = (gate_lvl == gate_polarity);        // RULE_01 RULE_02
  assign run = counter_on &&                             // RULE_03 RULE_10
               (!gate_enable_bit || gate_open);          // RULE_04

  gtc_prescaler #(
    .SEL_W(gtc_pkg::PS_W)
  ) u_prescaler (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .tick_in(src_tick && run),
    .sel_in(prescale_select),                            // RULE_05
    .clr_in(ctrl_wr),
    .tick_out(count_up)
  );

  // software write beats a same-cycle increment
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= gtc_pkg::COUNT_RST;
    end else if (count_wr) begin
      count <= pwdata_in[CNT_W-1:0];
    end else if (count_up) begin
      count <= count + CNT_W'(1);                        // RULE_12
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rollover_out <= 1'b0;
    end else begin
      rollover_out <= !count_wr && count_up && (&count);
    end
  end

  assign count_value_out = count;

  // assertions

  sequence s_hold;
    $stable(count);
  endsequence

  sequence s_step;
    count == $past(count) + CNT_W'(1);
  endsequence

  property p_gate_closed;
    @(posedge mclk_in) disable iff (!nrst_in)
      counter_on && gate_enable_bit && (gate_lvl != gate_polarity) &&
      !count_wr |=> s_hold;
  endproperty
  a_gate_closed: assert property (p_gate_closed) // RULE_01
    else $error("count moved while gate closed");

  property p_cmp_gate;
    @(posedge mclk_in) disable iff (!nrst_in)
      counter_on && gate_enable_bit && gate_source_select &&
      (cmp_s2 == gate_polarity) && !clock_source_select &&
      prescale_select == gtc_pkg::PS_DIV1 && !count_wr |=> s_step;
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) // RULE_02
    else $error("comparator gate did not open counting");

  property p_off_holds;
    @(posedge mclk_in) disable iff (!nrst_in)
      !counter_on && !count_wr |=> s_hold;
  endproperty
  a_off_holds: assert property (p_off_holds) // RULE_10
    else $error("count changed while counter off");

  property p_ge_ignored_off;
    @(posedge mclk_in) disable iff (!nrst_in)
      !counter_on && gate_enable_bit && gate_open && !count_wr
      |=> !count_up and s_hold;
  endproperty
  a_ge_ignored_off: assert property (p_ge_ignored_off) // RULE_03
    else $error("gate enable acted with counter off");

  property p_free_run;
    @(posedge mclk_in) disable iff (!nrst_in)
      counter_on && !gate_enable_bit && !clock_source_select &&
      prescale_select == gtc_pkg::PS_DIV1 && !count_wr |=> s_step;
  endproperty
  a_free_run: assert property (p_free_run) // RULE_04
    else $error("ungated internal count missed a cycle");

  property p_div8;
    @(posedge mclk_in) disable iff (!nrst_in)
      count_up && prescale_select == gtc_pkg::PS_DIV8
      |=> (!count_up || prescale_select != gtc_pkg::PS_DIV8)[*7];
  endproperty
  a_div8: assert property (p_div8) // RULE_05
    else $error("divide by eight ticked too soon");

  property p_osc_out;
    @(posedge mclk_in) disable iff (!nrst_in)
      ctrl_wr |=> low_power_osc_enable_out ==
                  $past(pwdata_in[gtc_pkg::OSC_EN_BIT]);
  endproperty
  a_osc_out: assert property (p_osc_out) // RULE_06
    else $error("oscillator enable output wrong after write");

  sequence s_ext_edge(logic nosync);
    ext_rise && clock_source_select && counter_on && !gate_enable_bit &&
    ext_clock_sync_control == nosync &&
    prescale_select == gtc_pkg::PS_DIV1 && !psel_in;
  endsequence

  property p_ext_sync;
    @(posedge mclk_in) disable iff (!nrst_in)
      s_ext_edge(1'b0) |=> s_hold ##1 s_step;
  endproperty
  a_ext_sync: assert property (p_ext_sync) // RULE_07
    else $error("synchronised edge not counted one cycle late");

  property p_ext_nosync;
    @(posedge mclk_in) disable iff (!nrst_in)
      s_ext_edge(1'b1) |=> s_step;
  endproperty
  a_ext_nosync: assert property (p_ext_nosync) // RULE_07
    else $error("unsynchronised edge not counted next cycle");

  property p_int_ignores_sync;
    @(posedge mclk_in) disable iff (!nrst_in)
      ext_clock_sync_control && !clock_source_select && run &&
      prescale_select == gtc_pkg::PS_DIV1 |-> count_up;
  endproperty
  a_int_ignores_sync: assert property (p_int_ignores_sync) // RULE_08
    else $error("sync bit disturbed internal counting");

  property p_ext_no_edge;
    @(posedge mclk_in) disable iff (!nrst_in)
      clock_source_select && !ext_tick && !count_wr |=> s_hold;
  endproperty
  a_ext_no_edge: assert property (p_ext_no_edge) // RULE_09
    else $error("external source counted without an edge");

  property p_only_step;
    @(posedge mclk_in) disable iff (!nrst_in)
      !$stable(count) |-> $past(count_wr) || $past(count_up && run);
  endproperty
  a_only_step: assert property (p_only_step) // RULE_12
    else $error("count changed without tick or write");

  property p_apb_ready;
    @(posedge mclk_in) disable iff (!nrst_in)
      psel_in && !penable_in ##1 psel_in && penable_in |=> pready_out;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb access not answered after one wait");

endmodule : gtc_top

// ### dv/gtc_partner.sv
`timescale 1ns/1ps
module gtc_partner (
  // clock
  input wire logic mclk_in,
  // pins toward the timer
  output logic ext_pin_out,
  output logic lp_osc_out,
  output logic gate_out,
  output logic comp_out
);
  initial begin
    ext_pin_out = 1'b0;
    lp_osc_out = 1'b0;
    gate_out = 1'b0;
    comp_out = 1'b0;
  end
  // 2 high, 3 low: slow enough for the 2-flop sync; idle low between
  task automatic burst(input int n, input bit osc);
    repeat (n) begin
      @(posedge mclk_in);
      if (osc) lp_osc_out <= 1'b1;
      else ext_pin_out <= 1'b1;
      repeat (2) @(posedge mclk_in);
      lp_osc_out <= 1'b0;
      ext_pin_out <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
  endtask : burst
  task automatic set_gate(input bit g, input bit c);
    @(posedge mclk_in);
    gate_out <= g;
    comp_out <= c;
  endtask : set_gate
endmodule : gtc_partner

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, ext_pin, lp_osc, gate, comp, osc_en, roll;
  logic [15:0] cnt;
  logic [31:0] q;
  logic e;
  int num_errors = 0;
  int tests_run = 0;

  always #25 mclk_in = ~mclk_in;

  gtc_top #(.CNT_W(16)) u_gtc_top (
    .mclk_in(mclk_in), .nrst_in(nrst_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .ext_count_clock_pin_in(ext_pin), .lp_osc_clock_in(lp_osc),
    .gate_pin_in(gate), .second_comparator_output_in(comp),
    .low_power_osc_enable_out(osc_en), .count_value_out(cnt),
    .rollover_out(roll));

  gtc_partner u_gtc_partner (
    .mclk_in(mclk_in), .ext_pin_out(ext_pin), .lp_osc_out(lp_osc),
    .gate_out(gate), .comp_out(comp));

  task automatic report_and_stop;
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // wait state count is the slave's business: poll pready, bounded
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic delta(input int n, input logic [15:0] exp);
    logic [15:0] a;
    logic [15:0] d;
    @(posedge mclk_in);
    #1 a = cnt;
    repeat (n) @(posedge mclk_in);
    #1 d = cnt - a;
    chk({16'h0000, d}, {16'h0000, exp});
  endtask : delta

  task automatic t_reset;
    apb(1'b0, gtc_pkg::CTRL_OFF, 32'h0);
    chk(q, 32'h00000000);
    apb(1'b0, gtc_pkg::GATE_SRC_OFF, 32'h0);
    chk(q, 32'h00000000);
    chk({31'h0, osc_en}, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h040, 32'hFF);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, gtc_pkg::CTRL_OFF, 32'h0);
    chk(q, 32'h00000000);
  endtask : t_reset

  task automatic t_prescale;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, gtc_pkg::CTRL_OFF, {26'h0, k[1:0], 4'h1});
      apb(1'b0, gtc_pkg::CTRL_OFF, 32'h0);
      chk(q, {26'h0, k[1:0], 4'h1});
      delta(64, 16'(64 >> k));
    end
    apb(1'b1, gtc_pkg::CTRL_OFF, 32'h05);
    delta(64, 16'h0040);
  endtask : t_prescale

  task automatic t_hold;
    apb(1'b1, gtc_pkg::CTRL_OFF, 32'h01);
    repeat (10) @(posedge mclk_in);
    apb(1'b1, gtc_pkg::CTRL_OFF, 32'h00);
    repeat (3) @(posedge mclk_in);
    delta(20, 16'h0000);
  endtask : t_hold

  task automatic gcase(input logic [7:0] ctl, input logic gss,
                       input logic g, input logic c,
                       input logic [15:0] exp);
    apb(1'b1, gtc_pkg::GATE_SRC_OFF, {31'h0, gss});
    apb(1'b1, gtc_pkg::CTRL_OFF, {24'h0, ctl});
    u_gtc_partner.set_gate(g, c);
    repeat (4) @(posedge mclk_in);
    delta(32, exp);
    apb(1'b0, gtc_pkg::STATUS_OFF, 32'h0);
    chk({31'h0, q[1]}, {31'h0, exp != 16'h0000});
  endtask : gcase

  task automatic t_gate;
    gcase(8'hC1, 1'b0, 1'b1, 1'b0, 16'h0020);
    gcase(8'hC1, 1'b0, 1'b0, 1'b1, 16'h0000);
    gcase(8'h41, 1'b0, 1'b0, 1'b1, 16'h0020);
    gcase(8'h41, 1'b0, 1'b1, 1'b0, 16'h0000);
    gcase(8'hC1, 1'b1, 1'b0, 1'b1, 16'h0020);
    gcase(8'h41, 1'b1, 1'b0, 1'b1, 16'h0000);
    gcase(8'h81, 1'b0, 1'b0, 1'b0, 16'h0020);
    gcase(8'hC0, 1'b0, 1'b1, 1'b1, 16'h0000);
  endtask : t_gate

  task automatic ecase(input logic [7:0] ctl, input bit osc);
    logic [15:0] a;
    apb(1'b1, gtc_pkg::CTRL_OFF, {24'h0, ctl});
    repeat (4) @(posedge mclk_in);
    #1 a = cnt;
    u_gtc_partner.burst(5, osc);
    repeat (8) @(posedge mclk_in);
    #1 chk({16'h0, cnt - a}, 32'h5);
  endtask : ecase

  task automatic t_ext;
    ecase(8'h03, 1'b0);
    ecase(8'h07, 1'b0);
    ecase(8'h0B, 1'b1);
    chk({31'h0, osc_en}, 32'h1);
  endtask : t_ext

  task automatic t_roll;
    int n;
    apb(1'b1, gtc_pkg::CTRL_OFF, 32'h00);
    apb(1'b1, gtc_pkg::COUNT_OFF, 32'hFFFC);
    apb(1'b0, gtc_pkg::COUNT_OFF, 32'h0);
    chk(q, 32'h0000FFFC);
    apb(1'b1, gtc_pkg::CTRL_OFF, 32'h01);
    n = 0;
    while (roll !== 1'b1 && n < 20) begin
      @(posedge mclk_in);
      #1 n++;
    end
    chk({31'h0, roll}, 32'h1);
    chk({16'h0, cnt}, 32'h0);
  endtask : t_roll

  initial begin
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_prescale();
    t_hold();
    t_gate();
    t_ext();
    t_roll();
    report_and_stop();
  end

  // whole run is about a thousand cycles
  initial begin
    #(50 * 20000);
    num_errors++;
    report_and_stop();
  end
endmodule : testbench
